// file: vss_pkg.sv
package vss_pkg;

    // register offsets on the internal register port
    localparam logic [7:0] ADDR_CLAMP_SLOTS78 = 8'h01;
    localparam logic [7:0] ADDR_PED_SLOTS56   = 8'h02;
    localparam logic [7:0] ADDR_SLOTS34       = 8'h03;
    localparam logic [7:0] ADDR_SLOTS12       = 8'h04;

    // reset values of the four registers
    localparam logic [7:0] RST_CLAMP_SLOTS78 = 8'h3f;
    localparam logic [7:0] RST_PED_SLOTS56   = 8'h49;
    localparam logic [7:0] RST_SLOTS34       = 8'h17;
    localparam logic [7:0] RST_SLOTS12       = 8'h01;

    // field positions
    localparam int CLAMP_SEL_LSB = 6;
    localparam int PEDESTAL_BIT  = 6;
    localparam int SLOT_PAIR_MSB = 5;
    localparam int SLOT_HI_LSB   = 3;
    localparam int ENTRY_W       = 3;
    localparam int ENTRIES       = 8;
    localparam int TABLE_W       = 24;

    // clamp target selections
    localparam logic [1:0] CLAMP_AUTO     = 2'h0;
    localparam logic [1:0] CLAMP_FORCE_50 = 2'h1;
    localparam logic [1:0] CLAMP_FORCE_60 = 2'h2;
    localparam logic [1:0] CLAMP_AUTO_ALT = 2'h3;

    // clamp target codes at the converter output
    localparam logic [9:0] BLANK_CODE_50 = 10'h100;
    localparam logic [9:0] BLANK_CODE_60 = 10'h0f4;

    // standard codes held in the search table
    localparam logic [2:0] STD_PAL_BGDHI = 3'h0;
    localparam logic [2:0] STD_SECAM     = 3'h1;
    localparam logic [2:0] STD_NTSC_M    = 3'h2;
    localparam logic [2:0] STD_PAL_M     = 3'h3;
    localparam logic [2:0] STD_PAL_N     = 3'h4;
    localparam logic [2:0] STD_NTSC_443  = 3'h5;
    localparam logic [2:0] STD_NONE_A    = 3'h6;
    localparam logic [2:0] STD_NONE_B    = 3'h7;

    // field-rate search modes
    localparam logic [1:0] FRS_AUTO_50   = 2'h0;
    localparam logic [1:0] FRS_FORCED_60 = 2'h1;
    localparam logic [1:0] FRS_FORCED_50 = 2'h2;
    localparam logic [1:0] FRS_AUTO_60   = 2'h3;

    // luma gain and offset per pedestal state, unsigned 1.7 gain
    localparam logic [7:0] Y_GAIN_PEDESTAL   = 8'h8a;
    localparam logic [7:0] Y_OFFSET_PEDESTAL = 8'h10;
    localparam logic [7:0] Y_GAIN_FLAT       = 8'h80;
    localparam logic [7:0] Y_OFFSET_FLAT     = 8'h00;

    // dwell time on one table entry during the standard search
    localparam int CLK_PERIOD_NS = 4;
    localparam int TRY_TIME_NS   = 40000;
    localparam int TRY_CYCLES    = TRY_TIME_NS / CLK_PERIOD_NS;
    localparam int TRY_CNT_W     = 14;

    // true for the two codes that mean no standard
    function automatic logic is_no_std(input logic [2:0] code);
        return (code == STD_NONE_A) || (code == STD_NONE_B);
    endfunction

endpackage

// file: vss_std_search.sv
`timescale 1ns/100ps
// walks the priority table, dwelling on each valid entry until the decoder reports a match
module vss_std_search #(
    parameter int unsigned TRY_CYCLES = vss_pkg::TRY_CYCLES
) (
    input  wire logic        sys_clk_i,    // system clock
    input  wire logic        arst_n_i,     // async reset, active low
    input  wire logic [23:0] table_i,      // entry one in bits 23:21
    input  wire logic        auto_i,       // automatic standard search on
    input  wire logic        restart_i,    // table rewritten, start over
    input  wire logic        match_i,      // decoder locks on tried standard
    output logic      [2:0]  try_code_o,   // standard now tried
    output logic      [2:0]  try_index_o,  // entry index, 0 is entry one
    output logic             locked_o,     // search settled on an entry
    output logic             empty_o       // no usable entry in table
);

    typedef enum logic [2:0] {
        SRCH_IDLE   = 3'b001,
        SRCH_TRY    = 3'b010,
        SRCH_LOCKED = 3'b100
    } vss_srch_e;

    vss_srch_e                          state;
    logic [vss_pkg::TRY_CNT_W-1:0]      dwell;
    logic [3:0]                         first_hit;
    logic [3:0]                         next_hit;
    logic                               dwell_done;

    localparam logic [vss_pkg::TRY_CNT_W-1:0] DWELL_LAST = vss_pkg::TRY_CNT_W'(TRY_CYCLES - 1);

    // first entry from 'from' onward, wrapping, that holds a real standard
    function automatic logic [3:0] next_valid(input logic [23:0] tbl, input logic [2:0] from);
        logic [3:0] res;
        logic [2:0] idx;
        res = 4'h0;
        for (int i = vss_pkg::ENTRIES - 1; i >= 0; i--) begin
            idx = 3'(from + 3'(i));
            if (!vss_pkg::is_no_std(tbl[23 - 3 * idx -: 3])) begin
                res = {1'b1, idx};
            end
        end
        return res;
    endfunction

    assign first_hit  = next_valid(table_i, 3'h0);
    assign next_hit   = next_valid(table_i, 3'(try_index_o + 3'h1));
    assign dwell_done = (dwell == DWELL_LAST);
    assign try_code_o = table_i[23 - 3 * try_index_o -: 3];
    assign locked_o   = (state == SRCH_LOCKED);
    assign empty_o    = !first_hit[3];

    // search sequencer; a table write always restarts from entry one
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state       <= SRCH_IDLE;
            try_index_o <= 3'h0;
            dwell       <= '0;
        end else if (restart_i || !auto_i) begin
            state <= SRCH_IDLE;
            dwell <= '0;
        end else begin
            unique case (state)
                SRCH_IDLE: begin
                    if (first_hit[3]) begin
                        state       <= SRCH_TRY;
                        try_index_o <= first_hit[2:0];
                        dwell       <= '0;
                    end
                end
                SRCH_TRY: begin
                    if (match_i) begin
                        state <= SRCH_LOCKED;
                    end else if (dwell_done) begin
                        try_index_o <= next_hit[2:0]; // see [RULE17]
                        dwell       <= '0;
                    end else begin
                        dwell <= dwell + 1'b1;
                    end
                end
                SRCH_LOCKED: begin
                    // lost lock: fall back to highest priority first
                    if (!match_i) begin
                        state <= SRCH_IDLE;
                    end
                end
                default: begin
                    state <= SRCH_IDLE;
                end
            endcase
        end
    end

endmodule

// file: vss_config.sv
`timescale 1ns/100ps
// Summary of operation
// [RULE1] selected blanking code drives the clamp loop target
// [RULE2] auto setting picks 256 for 50 Hz, 244 for 60 Hz; auto at reset
// [RULE3] setting 01 forces 256, 10 forces 244, 11 acts as auto
// [RULE4] automatic search tries only table standards, order is priority
// [RULE5] entry codes name six standards; 110 and 111 mean no standard
// [RULE6] table pairs live at 04h, 03h, 02h, 01h in bits 5:0
// [RULE7] upper three bits hold the odd entry, lower three the even one
// [RULE8] entries seven and eight reset to no standard
// [RULE9] entries one to four reset to PAL BGDHI, SECAM, NTSC M, none
// [RULE10] entries five and six reset to SECAM
// [RULE11] pedestal flag 0 means present, 1 absent; resets to 1
// [RULE12] pedestal flag selects luma gain and offset for all standards
// [RULE13] pedestal correction goes to both composite and RGB paths
// [RULE14] software writes zero to reserved high bits of 02h, 03h, 04h
// [RULE15] auto clamp target follows each 50/60 Hz identification change
// [RULE16] vsync search starts from configured field-rate mode
// [RULE17] search steps entry one to eight, skips none codes, wraps
module vss_config #(
    parameter int unsigned TRY_CYCLES = vss_pkg::TRY_CYCLES
) (
    input  wire logic       sys_clk_i,             // system clock, 250 MHz
    input  wire logic       arst_n_i,              // async reset, active low
    input  wire logic [7:0] reg_addr_i,            // register address
    input  wire logic [7:0] reg_wdata_i,           // write data
    input  wire logic       reg_wr_i,              // write strobe, one cycle
    input  wire logic       reg_rd_i,              // read strobe, one cycle
    output logic      [7:0] reg_rdata_o,           // read data, registered
    input  wire logic [1:0] field_rate_search_mode_i, // field-rate mode
    input  wire logic       vsync_ident_valid_i,   // vsync id result valid
    input  wire logic       vsync_is_60hz_i,       // id result: 1 is 60 Hz
    input  wire logic       std_auto_i,            // automatic standard search
    input  wire logic       std_match_i,           // chroma decoder matches
    output logic      [9:0] clamp_target_o,        // clamp loop target code
    output logic            vsync_start_60hz_o,    // search starts at 60 Hz
    output logic            vsync_forced_o,        // search held to one rate
    output logic      [2:0] std_try_code_o,        // standard under trial
    output logic      [2:0] std_try_index_o,       // entry under trial
    output logic            std_locked_o,          // search settled
    output logic            std_table_empty_o,     // table has no standard
    output logic            pedestal_absent_o,     // pedestal flag state
    output logic      [7:0] cvbs_y_gain_o,         // composite luma gain
    output logic      [7:0] cvbs_y_offset_o,       // composite luma offset
    output logic      [7:0] rgb_y_gain_o,          // rgb luma gain
    output logic      [7:0] rgb_y_offset_o         // rgb luma offset
);

    logic [1:0]  clamp_target_select;
    logic [5:0]  slots78;
    logic [5:0]  slots56;
    logic [5:0]  slots34;
    logic [5:0]  slots12;
    logic        pedestal_absent;
    logic        ident_60hz;
    logic        table_wr;
    logic [23:0] standard_search_table;
    logic [9:0]  next_clamp_target;
    logic [7:0]  next_rdata;

    // blanking target for a selection and identified field rate
    function automatic logic [9:0] blank_code(input logic [1:0] sel, input logic is60);
        logic [9:0] code;
        code = is60 ? vss_pkg::BLANK_CODE_60 : vss_pkg::BLANK_CODE_50;
        if (sel == vss_pkg::CLAMP_FORCE_50) begin
            code = vss_pkg::BLANK_CODE_50;
        end else if (sel == vss_pkg::CLAMP_FORCE_60) begin
            code = vss_pkg::BLANK_CODE_60;
        end
        return code;
    endfunction

    // write-decode helper, one hit per mapped address
    function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
        return wr && (a == ofs);
    endfunction

    // register 01h: clamp selection and entries seven and eight
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clamp_target_select <= vss_pkg::RST_CLAMP_SLOTS78[7:6];  // see [RULE2]
            slots78             <= vss_pkg::RST_CLAMP_SLOTS78[5:0];  // see [RULE8]
        end else if (wr_hit(reg_wr_i, reg_addr_i, vss_pkg::ADDR_CLAMP_SLOTS78)) begin
            clamp_target_select <= reg_wdata_i[vss_pkg::CLAMP_SEL_LSB +: 2];
            slots78             <= reg_wdata_i[vss_pkg::SLOT_PAIR_MSB:0];  // see [RULE6]
        end
    end

    // register 02h: pedestal flag and entries five and six
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pedestal_absent <= vss_pkg::RST_PED_SLOTS56[6];  // see [RULE11]
            slots56         <= vss_pkg::RST_PED_SLOTS56[5:0]; // see [RULE10]
        end else if (wr_hit(reg_wr_i, reg_addr_i, vss_pkg::ADDR_PED_SLOTS56)) begin
            pedestal_absent <= reg_wdata_i[vss_pkg::PEDESTAL_BIT];
            slots56         <= reg_wdata_i[vss_pkg::SLOT_PAIR_MSB:0]; // see [RULE6]
        end
    end

    // registers 03h and 04h: entries one to four; bits 7:6 are not stored
    // since software keeps them zero, see [RULE14]
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            slots34 <= vss_pkg::RST_SLOTS34[5:0];  // see [RULE9]
            slots12 <= vss_pkg::RST_SLOTS12[5:0];  // see [RULE9]
        end else begin
            if (wr_hit(reg_wr_i, reg_addr_i, vss_pkg::ADDR_SLOTS34)) begin
                slots34 <= reg_wdata_i[vss_pkg::SLOT_PAIR_MSB:0]; // see [RULE6]
            end
            if (wr_hit(reg_wr_i, reg_addr_i, vss_pkg::ADDR_SLOTS12)) begin
                slots12 <= reg_wdata_i[vss_pkg::SLOT_PAIR_MSB:0]; // see [RULE6]
            end
        end
    end

    // entry one lands in the top three bits: odd entry is the upper half of each pair
    assign standard_search_table = {slots12, slots34, slots56, slots78}; // see [RULE7]
    assign table_wr = reg_wr_i && (reg_addr_i >= vss_pkg::ADDR_CLAMP_SLOTS78)
                      && (reg_addr_i <= vss_pkg::ADDR_SLOTS12);

    // read mux; reserved and unmapped bits answer zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr_i)
            vss_pkg::ADDR_CLAMP_SLOTS78: next_rdata = {clamp_target_select, slots78};
            vss_pkg::ADDR_PED_SLOTS56:   next_rdata = {1'b0, pedestal_absent, slots56};
            vss_pkg::ADDR_SLOTS34:       next_rdata = {2'b00, slots34};
            vss_pkg::ADDR_SLOTS12:       next_rdata = {2'b00, slots12};
            default:                     next_rdata = 8'h00;
        endcase
    end

    // read data is captured on the strobe and held until the next read
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // last vsync identification; 50 Hz until the first result arrives
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ident_60hz <= 1'b0;
        end else if (vsync_ident_valid_i) begin
            ident_60hz <= vsync_is_60hz_i;  // see [RULE15]
        end
    end

    // clamp target is re-derived every cycle, so an identification change
    // reaches the clamp two cycles after the valid strobe
    assign next_clamp_target = blank_code(clamp_target_select, ident_60hz); // see [RULE2] [RULE3]

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clamp_target_o <= vss_pkg::BLANK_CODE_50;
        end else begin
            clamp_target_o <= next_clamp_target;  // see [RULE1]
        end
    end

    // vsync search start point decoded from the field-rate mode
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            vsync_start_60hz_o <= 1'b0;
            vsync_forced_o     <= 1'b0;
        end else begin
            vsync_start_60hz_o <= (field_rate_search_mode_i == vss_pkg::FRS_FORCED_60)
                                  || (field_rate_search_mode_i == vss_pkg::FRS_AUTO_60); // see [RULE16]
            vsync_forced_o     <= (field_rate_search_mode_i == vss_pkg::FRS_FORCED_60)
                                  || (field_rate_search_mode_i == vss_pkg::FRS_FORCED_50); // see [RULE16]
        end
    end

    // luma correction, one setting for every standard, fed to both paths
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pedestal_absent_o <= 1'b1;
            cvbs_y_gain_o     <= vss_pkg::Y_GAIN_FLAT;
            cvbs_y_offset_o   <= vss_pkg::Y_OFFSET_FLAT;
            rgb_y_gain_o      <= vss_pkg::Y_GAIN_FLAT;
            rgb_y_offset_o    <= vss_pkg::Y_OFFSET_FLAT;
        end else begin
            pedestal_absent_o <= pedestal_absent;
            cvbs_y_gain_o     <= pedestal_absent ? vss_pkg::Y_GAIN_FLAT : vss_pkg::Y_GAIN_PEDESTAL; // see [RULE12]
            cvbs_y_offset_o   <= pedestal_absent ? vss_pkg::Y_OFFSET_FLAT : vss_pkg::Y_OFFSET_PEDESTAL;
            rgb_y_gain_o      <= pedestal_absent ? vss_pkg::Y_GAIN_FLAT : vss_pkg::Y_GAIN_PEDESTAL; // see [RULE13]
            rgb_y_offset_o    <= pedestal_absent ? vss_pkg::Y_OFFSET_FLAT : vss_pkg::Y_OFFSET_PEDESTAL;
        end
    end

    // priority search over the table; no-standard codes are never tried
    vss_std_search #(
        .TRY_CYCLES (TRY_CYCLES)
    ) u_search (
        .sys_clk_i   (sys_clk_i),
        .arst_n_i    (arst_n_i),
        .table_i     (standard_search_table),  // see [RULE4]
        .auto_i      (std_auto_i),
        .restart_i   (table_wr),
        .match_i     (std_match_i),
        .try_code_o  (std_try_code_o),         // see [RULE5]
        .try_index_o (std_try_index_o),
        .locked_o    (std_locked_o),
        .empty_o     (std_table_empty_o)
    );

    // checks on the design's own outputs
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    a_clamp_forced_50: assert property ( // see [RULE3]
        clamp_target_select == vss_pkg::CLAMP_FORCE_50 ##1 clamp_target_select == vss_pkg::CLAMP_FORCE_50
        |-> clamp_target_o == 10'h100)
        else $error("forced 50 Hz clamp target is not 256");

    a_clamp_forced_60: assert property ( // see [RULE3]
        clamp_target_select == vss_pkg::CLAMP_FORCE_60 ##1 clamp_target_select == vss_pkg::CLAMP_FORCE_60
        |-> clamp_target_o == 10'h0f4)
        else $error("forced 60 Hz clamp target is not 244");

    a_clamp_auto_follow: assert property ( // see [RULE15]
        (clamp_target_select[0] == clamp_target_select[1]) && vsync_ident_valid_i
        ##1 (clamp_target_select[0] == clamp_target_select[1])
        |=> clamp_target_o == ($past(vsync_is_60hz_i, 2) ? 10'h0f4 : 10'h100))
        else $error("auto clamp target does not follow vsync identification");

    a_no_std_skipped: assert property ( // see [RULE17]
        std_auto_i && !std_table_empty_o |-> !vss_pkg::is_no_std(std_try_code_o) || !$past(std_auto_i))
        else $error("search tries an entry holding no standard");

    a_lock_on_match: assert property ( // see [RULE4]
        std_auto_i && !table_wr && std_match_i && !std_table_empty_o
        ##1 std_auto_i && !table_wr && std_match_i |-> ##1 std_locked_o)
        else $error("search did not lock on a matching standard");

    a_pedestal_paths: assert property ( // see [RULE13]
        cvbs_y_gain_o == rgb_y_gain_o && cvbs_y_offset_o == rgb_y_offset_o)
        else $error("composite and rgb luma correction differ");

    a_pedestal_gain: assert property ( // see [RULE12]
        $changed(pedestal_absent) |=> cvbs_y_gain_o ==
            ($past(pedestal_absent) ? vss_pkg::Y_GAIN_FLAT : vss_pkg::Y_GAIN_PEDESTAL))
        else $error("luma gain does not follow pedestal flag");

    a_reserved_read: assert property ( // see [RULE14]
        reg_rd_i && (reg_addr_i == vss_pkg::ADDR_SLOTS34 || reg_addr_i == vss_pkg::ADDR_SLOTS12)
        |=> reg_rdata_o[7:6] == 2'b00)
        else $error("reserved table bits read as nonzero");

    a_write_readback: assert property ( // see [RULE6]
        reg_wr_i && reg_addr_i == vss_pkg::ADDR_SLOTS12 ##1 reg_rd_i && reg_addr_i == vss_pkg::ADDR_SLOTS12
        |=> {2'b00, reg_rdata_o[5:0]} == ($past(reg_wdata_i, 2) & 8'h3f))
        else $error("entries one and two do not read back");

    a_vsync_start: assert property ( // see [RULE16]
        $stable(field_rate_search_mode_i) && field_rate_search_mode_i == vss_pkg::FRS_FORCED_50
        |=> !vsync_start_60hz_o && vsync_forced_o)
        else $error("forced 50 Hz vsync start decoded wrongly");

    c_auto_60: cover property (
        clamp_target_select == vss_pkg::CLAMP_AUTO && clamp_target_o == vss_pkg::BLANK_CODE_60);
    c_search_lock: cover property (std_locked_o && std_try_index_o != 3'h0);
    // a wrap shows as the index falling back to entry one while still searching
    c_search_wrap: cover property (std_try_index_o != 3'h0 ##1 std_try_index_o == 3'h0 && std_auto_i);
    c_pedestal_on: cover property (!pedestal_absent_o);

endmodule

// file: vss_tb.sv
`timescale 1ns/100ps
module testbench;
    localparam int unsigned TRY = 8;   // short dwell keeps the search walk quick
    logic       sys_clk_i, arst_n_i, reg_wr_i, reg_rd_i, vld, is60, auto, match;
    logic [7:0] addr, wdata, rdata, cg, co, rg, ro;
    logic [1:0] mode;
    logic [9:0] clamp;
    logic [2:0] code, idx;
    logic       st60, frc, lck, emp, ped;
    int         n_fail, n_checks, seed, i;
    int         walk [6] = '{0, 1, 2, 4, 5, 0};   // entry four and seven/eight hold no standard
    logic [2:0] dcode [8] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h1, 3'h1, 3'h7, 3'h7};

    vss_config #(.TRY_CYCLES(TRY)) u_dut (
        .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .field_rate_search_mode_i(mode),
        .vsync_ident_valid_i(vld), .vsync_is_60hz_i(is60), .std_auto_i(auto), .std_match_i(match),
        .clamp_target_o(clamp), .vsync_start_60hz_o(st60), .vsync_forced_o(frc), .std_try_code_o(code),
        .std_try_index_o(idx), .std_locked_o(lck), .std_table_empty_o(emp), .pedestal_absent_o(ped),
        .cvbs_y_gain_o(cg), .cvbs_y_offset_o(co), .rgb_y_gain_o(rg), .rgb_y_offset_o(ro));

    // clock generation, 4 ns period
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    // reserved high bits are not stored, unmapped places read zero
    function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [7:0] d);
        return (a == 8'h01) ? d : (a == 8'h02) ? (d & 8'h7f) : (a inside {8'h03, 8'h04}) ? (d & 8'h3f) : 8'h00;
    endfunction

    function automatic logic [9:0] exp_clamp(input logic [1:0] s, input logic h);
        return (s == 2'h1) ? vss_pkg::BLANK_CODE_50 : (s == 2'h2) ? vss_pkg::BLANK_CODE_60 :
               (h ? vss_pkg::BLANK_CODE_60 : vss_pkg::BLANK_CODE_50);
    endfunction

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        addr = a; wdata = d; reg_wr_i = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk_i);
        addr = a; reg_rd_i = 1'b1;
        @(negedge sys_clk_i);
        reg_rd_i = 1'b0;
        chk(rdata, exp);
    endtask

    task automatic end_of_test;
        $display("checks=%0d failures=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // watchdog sized well above the few hundred cycles of the sequence
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end

    initial begin
        {reg_wr_i, reg_rd_i, vld, is60, auto, match} = '0;
        {addr, wdata, mode} = '0;
        n_fail = 0; n_checks = 0; seed = 32'h290f;
        arst_n_i = 1'b0;
        repeat (10) @(negedge sys_clk_i);
        arst_n_i = 1'b1;
        // reset values, then an unmapped place
        rd(8'h01, 8'h3f);
        rd(8'h02, 8'h49);
        rd(8'h03, 8'h17);
        rd(8'h04, 8'h01);
        chk(ped, 1'b1);
        rd(8'h00, 8'h00);
        // random write and read back, reserved bits and unmapped writes dropped
        for (i = 0; i < 16; i++) begin
            logic [7:0] a, d;
            a = (i < 12) ? 8'(1 + i % 4) : 8'(5 + i);
            d = 8'($random(seed));
            wr(a, d);
            rd(a, exp_rd(a, d));
        end
        // clamp target over every select value, with a random field rate each time
        for (i = 0; i < 8; i++) begin
            is60 = 1'($random(seed));
            wr(8'h01, {2'(i / 2), 6'h3f});
            @(negedge sys_clk_i);
            vld = 1'b1;
            @(negedge sys_clk_i);
            vld = 1'b0;
            repeat (2) @(negedge sys_clk_i);
            chk(clamp, exp_clamp(2'(i / 2), is60));
        end
        // pedestal present, then absent again, on both luma paths
        wr(8'h02, 8'h09);
        @(negedge sys_clk_i);
        chk({ped, cg, co}, {1'b0, vss_pkg::Y_GAIN_PEDESTAL, vss_pkg::Y_OFFSET_PEDESTAL});
        chk({rg, ro}, {vss_pkg::Y_GAIN_PEDESTAL, vss_pkg::Y_OFFSET_PEDESTAL});
        wr(8'h02, 8'h49);
        @(negedge sys_clk_i);
        chk({ped, cg, rg, co, ro}, {1'b1, vss_pkg::Y_GAIN_FLAT, vss_pkg::Y_GAIN_FLAT, 16'h0});
        // field-rate search mode decoding
        for (i = 0; i < 4; i++) begin
            mode = 2'(i);
            repeat (2) @(negedge sys_clk_i);
            chk({st60, frc}, {1'(i % 2), 1'(i == 1 || i == 2)});
        end
        // search walk over the reset table: skips no-standard entries and wraps
        wr(8'h01, 8'h3f);
        wr(8'h03, 8'h17);
        wr(8'h04, 8'h01);
        auto = 1'b1;
        @(negedge sys_clk_i);
        for (i = 0; i < 6; i++) begin
            if (i > 0) repeat (TRY) @(negedge sys_clk_i);
            chk({idx, code}, {3'(walk[i]), dcode[walk[i]]});
        end
        match = 1'b1;
        @(negedge sys_clk_i);
        chk(lck, 1'b1);
        match = 1'b0;
        auto = 1'b0;
        // only entry one usable, then an all-empty table
        wr(8'h02, 8'h3f);
        wr(8'h03, 8'h3e);
        wr(8'h04, 8'h16);
        auto = 1'b1;
        repeat (TRY + 3) @(negedge sys_clk_i);
        chk({idx, code, emp}, {3'h0, vss_pkg::STD_NTSC_M, 1'b0});
        wr(8'h04, 8'h3f);
        chk(emp, 1'b1);
        end_of_test();
    end
endmodule
